// file: hw/logic_cell.sv
// storage elements, level-sensitive ram and fast carry of one logic cell
// assumes all cell pins are asynchronous to clk and an avalon-mm master on clk
`timescale 1ns/1ps
module logic_cell (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cellClock,
  input  wire logic        cellClockEnableIn,
  input  wire logic        localSetResetIn,
  input  wire logic        globalInitSignal,
  input  wire logic [1:0]  storeData,
  input  wire logic [3:0]  firstGenInputs,
  input  wire logic [3:0]  secondGenInputs,
  input  wire logic        cellDataInZero,
  input  wire logic        cellDataInOne,
  input  wire logic        writeEnable,
  input  wire logic        carryIn,
  input  wire logic        downwardCarryIn,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic [1:0]       q,
  output logic [1:0]       sum,
  output logic             carryOut,
  output logic             carryOutDown,
  output logic             carryOutRight,
  output logic [1:0]       ramOut
);

  logic_cell_pkg::state_s st;
  logic_cell_pkg::state_s next_st;
  logic_cell_pkg::pins_s  pinsNow;

  // byte-lane merge used by both writable registers
  function automatic logic [31:0] mergeLanes(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : mergeLanes

  // one storage element step
  function automatic logic storeStep(input logic qOld, input logic d, input logic latchMode,
                                     input logic rise, input logic fall, input logic level,
                                     input logic falling, input logic ce, input logic forceIn,
                                     input logic initVal);
    logic r;
    r = qOld;
    if (forceIn) begin
      r = initVal;
    end else if (ce) begin
      if (latchMode) begin
        if (level ^ falling) begin
          r = d;
        end
      end else if (falling ? fall : rise) begin
        r = d;
      end
    end
    return r;
  endfunction : storeStep

  always_comb begin
    pinsNow.cellClock         = cellClock;
    pinsNow.cellClockEnableIn = cellClockEnableIn;
    pinsNow.localSetResetIn   = localSetResetIn;
    pinsNow.globalInitSignal  = globalInitSignal;
    pinsNow.storeData         = storeData;
    pinsNow.firstGenInputs    = firstGenInputs;
    pinsNow.secondGenInputs   = secondGenInputs;
    pinsNow.cellDataInZero    = cellDataInZero;
    pinsNow.cellDataInOne     = cellDataInOne;
    pinsNow.writeEnable       = writeEnable;
    pinsNow.carryIn           = carryIn;
    pinsNow.downwardCarryIn   = downwardCarryIn;
  end

  logic        ext;
  logic        rise;
  logic        fall;
  logic [1:0]  ce;
  logic        srIn;
  logic        gInit;
  logic        cfgLoad;
  logic        doWrite;
  logic [3:0]  opA;
  logic [3:0]  opB;
  logic        cin;
  logic        c1;
  logic        c2;
  logic [4:0]  addr32;
  logic [31:0] ramNext;
  logic [31:0] cfgWord;

  always_comb begin
    next_st = st;
    next_st.syncA = pinsNow;
    next_st.syncB = st.syncA;
    next_st.clkPrev = st.syncB.cellClock;
    ext = st.cfg[logic_cell_pkg::CFG_EXTENDED];
    rise = st.syncB.cellClock & ~st.clkPrev;
    fall = ~st.syncB.cellClock & st.clkPrev;

    // avalon slave: one wait cycle, then answer
    doWrite = write & ~st.waitReq;
    next_st.waitReq = ~((read | write) & st.waitReq);
    gInit = st.syncB.globalInitSignal;
    cfgLoad = 1'b0;
    // lanes merged on a full word, only the low half is a real register
    cfgWord = mergeLanes({16'h0000, st.cfg}, writedata, byteenable);
    if (doWrite) begin
      unique case (address)
        logic_cell_pkg::OFS_CONFIG: begin
          next_st.cfg = cfgWord[15:0];
        end
        logic_cell_pkg::OFS_CONTROL: begin
          if (byteenable[0]) begin
            gInit = gInit | writedata[logic_cell_pkg::CTL_GLOBAL_INIT];
            cfgLoad = writedata[logic_cell_pkg::CTL_CONFIGURE];
          end
        end
        logic_cell_pkg::OFS_RAM_INIT: begin
          next_st.ramInit = mergeLanes(st.ramInit, writedata, byteenable);
        end
        default: begin
        end
      endcase
    end
    if ((read | write) & st.waitReq & read) begin
      unique case (address)
        logic_cell_pkg::OFS_CONFIG:   next_st.readData = {16'h0000, st.cfg};
        logic_cell_pkg::OFS_RAM_INIT: next_st.readData = st.ramInit;
        logic_cell_pkg::OFS_STATUS: begin
          next_st.readData = {22'h000000, st.ramOut, st.carryOutRight, st.carryOutDown, st.carryOut,
                              st.sum, st.syncB.cellClock, st.q};
        end
        default:                      next_st.readData = 32'h0000_0000;
      endcase
    end

    // storage elements; latch mode exists on the extended variant only
    ce[0] = st.cfg[logic_cell_pkg::CFG_CE_USE0] ? st.syncB.cellClockEnableIn : 1'b1;
    ce[1] = st.cfg[logic_cell_pkg::CFG_CE_USE1] ? st.syncB.cellClockEnableIn : 1'b1;
    srIn = st.cfg[logic_cell_pkg::CFG_SR_USE] & st.syncB.localSetResetIn;
    next_st.q[0] = storeStep(st.q[0], st.syncB.storeData[0], ext & st.cfg[logic_cell_pkg::CFG_LATCH],
                             rise, fall, st.syncB.cellClock, st.cfg[logic_cell_pkg::CFG_FALL0], ce[0],
                             srIn | gInit, st.cfg[logic_cell_pkg::CFG_SET0]);
    next_st.q[1] = storeStep(st.q[1], st.syncB.storeData[1], ext & st.cfg[logic_cell_pkg::CFG_LATCH],
                             rise, fall, st.syncB.cellClock, st.cfg[logic_cell_pkg::CFG_FALL1], ce[1],
                             srIn | gInit, st.cfg[logic_cell_pkg::CFG_SET1]);

    // level-sensitive single-port ram; global init never reaches it
    ramNext = st.ram;
    addr32 = {st.syncB.cellDataInOne, st.syncB.firstGenInputs};
    if (cfgLoad) begin
      ramNext = st.ramInit;
    end else if (st.cfg[logic_cell_pkg::CFG_RAM_EN] & st.syncB.writeEnable) begin
      if (st.cfg[logic_cell_pkg::CFG_RAM_32X1]) begin
        ramNext[addr32] = st.syncB.cellDataInZero;
      end else begin
        ramNext[{st.syncB.firstGenInputs, 1'b0}] = st.syncB.cellDataInZero;
        ramNext[{st.syncB.secondGenInputs, 1'b1}] = st.syncB.cellDataInOne;
      end
    end
    next_st.ram = ramNext;
    if (st.cfg[logic_cell_pkg::CFG_RAM_32X1]) begin
      next_st.ramOut = {1'b0, st.ram[addr32]};
    end else begin
      next_st.ramOut = {st.ram[{st.syncB.secondGenInputs, 1'b1}], st.ram[{st.syncB.firstGenInputs, 1'b0}]};
    end

    // two-bit add or subtract over operand pins shared with the generators
    opA = {2'b00, st.syncB.secondGenInputs[0], st.syncB.firstGenInputs[0]};
    opB = {2'b00, st.syncB.secondGenInputs[1], st.syncB.firstGenInputs[1]} ^
          {2'b00, {2{st.cfg[logic_cell_pkg::CFG_SUB]}}};
    if (ext) begin
      cin = st.syncB.carryIn;
    end else begin
      cin = st.cfg[logic_cell_pkg::CFG_DOWN] ? st.syncB.downwardCarryIn : st.syncB.carryIn;
    end
    c1 = (opA[0] & opB[0]) | (cin & (opA[0] ^ opB[0]));
    c2 = (opA[1] & opB[1]) | (c1 & (opA[1] ^ opB[1]));
    next_st.sum = {opA[1] ^ opB[1] ^ c1, opA[0] ^ opB[0] ^ cin};
    if (ext & st.cfg[logic_cell_pkg::CFG_G4_OUT]) begin
      c2 = st.cfg[logic_cell_pkg::CFG_G4_ZERO] ? 1'b0 : st.syncB.secondGenInputs[3];
    end
    next_st.carryOut = 1'b0;
    next_st.carryOutDown = 1'b0;
    next_st.carryOutRight = 1'b0;
    if (st.cfg[logic_cell_pkg::CFG_COL_END] & ~ext) begin
      next_st.carryOutRight = c2;
    end else if (st.cfg[logic_cell_pkg::CFG_DOWN] & ~ext) begin
      next_st.carryOutDown = c2;
    end else begin
      next_st.carryOut = c2;
    end
  end

  // power-up state: elements at reset value, ram zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.cfg <= logic_cell_pkg::CONFIG_RESET;
      st.ramInit <= logic_cell_pkg::RAM_INIT_RESET;
      st.waitReq <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign readdata      = st.readData;
  assign waitrequest   = st.waitReq;
  assign q             = st.q;
  assign sum           = st.sum;
  assign carryOut      = st.carryOut;
  assign carryOutDown  = st.carryOutDown;
  assign carryOutRight = st.carryOutRight;
  assign ramOut        = st.ramOut;

endmodule : logic_cell

// file: common/logic_cell_pkg.sv
// package for the logic cell storage, ram and carry block
// assumes a 25 MHz system clock and an avalon-mm master reaching the registers
// Notes on behaviour
// - two edge-triggered storage elements share one cell clock and one clock enable
// - each element picks rising or falling cell clock edge on its own
// - clock enable is active high, no per-element inversion
// - an unconnected clock enable acts as always asserted
// - extended variant lets both elements work as latches on shared clock and enable
// - flip-flop loads data on active edge with enable high, holds with enable low
// - an unconnected set/reset input counts as low
// - power-up or global init puts each element at its set or reset value
// - ram loads a per-instance initial value at configuration, zero by default
// - ram is untouched by the global init signal
// - single-port 32x1 ram uses one data bit, five address bits, write enable, one output
// - ram is organised as sixteen two-bit words or thirty-two one-bit words
// - each generator makes carry or borrow, passed on a dedicated path
// - the two generators form a two-bit adder chainable to any width
// - base variant carry runs up or down, turning right at column ends
// - extended variant carry runs upward only, no downward carry in
// - carry shares operands with the generators, which form the sum bits
// - extended variant lets input four of second generator drive carry out via a zero mux
package logic_cell_pkg;
  localparam logic [3:0]  OFS_CONFIG    = 4'h0;
  localparam logic [3:0]  OFS_CONTROL   = 4'h4;
  localparam logic [3:0]  OFS_RAM_INIT  = 4'h8;
  localparam logic [3:0]  OFS_STATUS    = 4'hc;
  localparam logic [15:0] CONFIG_RESET  = 16'h00c0;
  localparam logic [31:0] RAM_INIT_RESET = 32'h0000_0000;
  // config field positions
  localparam int CFG_FALL0    = 0;
  localparam int CFG_FALL1    = 1;
  localparam int CFG_LATCH    = 2;
  localparam int CFG_SET0     = 3;
  localparam int CFG_SET1     = 4;
  localparam int CFG_EXTENDED = 5;
  localparam int CFG_CE_USE0  = 6;
  localparam int CFG_CE_USE1  = 7;
  localparam int CFG_SR_USE   = 8;
  localparam int CFG_RAM_EN   = 9;
  localparam int CFG_RAM_32X1 = 10;
  localparam int CFG_DOWN     = 11;
  localparam int CFG_COL_END  = 12;
  localparam int CFG_SUB      = 13;
  localparam int CFG_G4_OUT   = 14;
  localparam int CFG_G4_ZERO  = 15;
  // control bits, self clearing
  localparam int CTL_GLOBAL_INIT = 0;
  localparam int CTL_CONFIGURE   = 1;

  typedef struct packed {
    logic       cellClock;
    logic       cellClockEnableIn;
    logic       localSetResetIn;
    logic       globalInitSignal;
    logic [1:0] storeData;
    logic [3:0] firstGenInputs;
    logic [3:0] secondGenInputs;
    logic       cellDataInZero;
    logic       cellDataInOne;
    logic       writeEnable;
    logic       carryIn;
    logic       downwardCarryIn;
  } pins_s;

  typedef struct packed {
    pins_s       syncA;
    pins_s       syncB;
    logic        clkPrev;
    logic [1:0]  q;
    logic [31:0] ram;
    logic [15:0] cfg;
    logic [31:0] ramInit;
    logic [1:0]  sum;
    logic        carryOut;
    logic        carryOutDown;
    logic        carryOutRight;
    logic [1:0]  ramOut;
    logic        waitReq;
    logic [31:0] readData;
  } state_s;
endpackage : logic_cell_pkg

// file: tb/cell_clock_source.sv
// far-side model: interconnect driving the cell clock pin
// assumes pulseReq is a one-cycle request on clk
`timescale 1ns/1ps
module cell_clock_source (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pulseReq,
  output logic      cellClock
);
  logic [3:0] count;
  // 6 clk high then 5 low, well above the 2 clk minimum phase; idle low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 4'h0;
    end else if (pulseReq || count != 4'h0) begin
      count <= (count == 4'hb) ? 4'h0 : count + 4'h1;
    end
  end
  assign cellClock = (count != 4'h0) && (count < 4'h7);
endmodule : cell_clock_source

// file: tb/logic_cell_chk.sv
// port checker for the logic cell
// assumes config writes use all byte lanes
`timescale 1ns/1ps
module logic_cell_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cellClock,
  input wire logic        cellClockEnableIn,
  input wire logic        localSetResetIn,
  input wire logic        globalInitSignal,
  input wire logic [1:0]  storeData,
  input wire logic [3:0]  firstGenInputs,
  input wire logic [3:0]  secondGenInputs,
  input wire logic        carryIn,
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic        waitrequest,
  input wire logic [1:0]  q,
  input wire logic [1:0]  sum,
  input wire logic        carryOut,
  input wire logic        carryOutDown,
  input wire logic        carryOutRight
);
  logic [15:0] cfg;
  logic [2:0]  addExp;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg <= logic_cell_pkg::CONFIG_RESET;
    end else if (write && !waitrequest && address == logic_cell_pkg::OFS_CONFIG) begin
      cfg <= writedata[15:0];
    end
  end
  // subtract inverts operand b, carry then reads as not-borrow
  assign addExp = {1'b0, secondGenInputs[0], firstGenInputs[0]}
                + {1'b0, {secondGenInputs[1], firstGenInputs[1]} ^ {2{cfg[13]}}} + {2'b00, carryIn};
  a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered next cycle");
  a_answer_once: assert property (!waitrequest |=> waitrequest)
    else $error("answer held too long");
  a_flop_load: assert property ($rose(cellClock) ##1 ($stable(storeData) && cellClockEnableIn &&
    !globalInitSignal && !localSetResetIn && cfg[2:0] == 3'b000)[*6] |-> q[0] == storeData[0])
    else $error("flop did not load on edge");
  a_enable_hold: assert property ((!cellClockEnableIn && !globalInitSignal && !localSetResetIn
    && cfg[7:6] == 2'b11)[*6] |-> $stable(q)) else $error("q moved with enable low");
  a_global_init: assert property (globalInitSignal[*5] |-> q == cfg[4:3])
    else $error("global init value wrong");
  a_set_reset: assert property ((localSetResetIn && cfg[8])[*5] |-> q == cfg[4:3])
    else $error("set/reset value wrong");
  a_adder_sum: assert property (($stable({firstGenInputs, secondGenInputs, carryIn, cfg})
    && !cfg[14] && cfg[12:9] == 4'h0)[*5] |-> {carryOut, sum} == addExp) else $error("adder result wrong");
  a_top_only: assert property (($stable(cfg) && cfg[5])[*3] |-> !carryOutDown && !carryOutRight)
    else $error("carry left other than at top");
  a_carry_down: assert property (($stable(cfg) && !cfg[5] && cfg[11] && !cfg[12])[*3]
    |-> !carryOut && !carryOutRight) else $error("carry left other than downward");
  a_g4_direct: assert property (($stable({secondGenInputs, cfg}) && cfg[5] && cfg[14])[*5]
    |-> carryOut == (secondGenInputs[3] && !cfg[15])) else $error("carry out not taken from input four");
endmodule : logic_cell_chk
bind logic_cell logic_cell_chk chk (.*);

// file: tb/logic_cell_tb_top.sv
// self-checking bench for the logic cell
// assumes the cell clock comes from the interconnect model
`timescale 1ns/1ps
module logic_cell_tb_top;
  logic clk, rst, cellClock, cellClockEnableIn, localSetResetIn, globalInitSignal, cellDataInZero;
  logic cellDataInOne, writeEnable, carryIn, downwardCarryIn, read, write, waitrequest, pulseReq;
  logic carryOut, carryOutDown, carryOutRight;
  logic [1:0]  storeData, q, sum, ramOut;
  logic [3:0]  firstGenInputs, secondGenInputs, address, byteenable;
  logic [31:0] writedata, readdata, rv;
  logic [2:0]  e;
  int mismatches, comparisons, cycles;
  logic_cell uut (.*);
  cell_clock_source far (.*);
  always #20 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rv = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic pulse(input int hi);
    @(posedge clk);
    pulseReq <= 1'b1;
    @(posedge clk);
    pulseReq <= 1'b0;
    repeat (hi) @(posedge clk);
  endtask : pulse
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  task automatic t_flop;
    bus(0, logic_cell_pkg::OFS_CONFIG, 0);
    check(rv, logic_cell_pkg::CONFIG_RESET);
    check(q, 2'b00);
    bus(0, 4'h2, 0);
    check(rv, 0);
    cellClockEnableIn <= 1'b1;
    storeData <= 2'b10;
    pulse(14);
    check(q, 2'b10);
    cellClockEnableIn <= 1'b0;
    storeData <= 2'b01;
    pulse(14);
    check(q, 2'b10);
    bus(1, logic_cell_pkg::OFS_CONFIG, 32'h0080);
    pulse(14);
    check(q, 2'b11);
    $display("flop test done");
  endtask : t_flop
  task automatic t_edge_init;
    bus(1, logic_cell_pkg::OFS_CONFIG, 32'h00c2);
    cellClockEnableIn <= 1'b1;
    storeData <= 2'b00;
    pulse(5);
    check(q, 2'b10);
    repeat (9) @(posedge clk);
    check(q, 2'b00);
    bus(1, logic_cell_pkg::OFS_CONFIG, 32'h00d8);
    bus(1, logic_cell_pkg::OFS_CONTROL, 32'h1);
    repeat (5) @(posedge clk);
    check(q, 2'b11);
    localSetResetIn <= 1'b1;
    bus(1, logic_cell_pkg::OFS_CONFIG, 32'h00c0);
    pulse(14);
    check(q, 2'b00);
    bus(1, logic_cell_pkg::OFS_CONFIG, 32'h01d8);
    repeat (5) @(posedge clk);
    check(q, 2'b11);
    localSetResetIn <= 1'b0;
    bus(1, logic_cell_pkg::OFS_CONFIG, 32'h00c0);
    globalInitSignal <= 1'b1;
    repeat (6) @(posedge clk);
    check(q, 2'b00);
    globalInitSignal <= 1'b0;
    $display("edge and init test done");
  endtask : t_edge_init
  task automatic t_latch;
    bus(1, logic_cell_pkg::OFS_CONFIG, 32'h00e4);
    pulse(1);
    storeData <= 2'b11;
    repeat (4) @(posedge clk);
    check(q, 2'b11);
    repeat (3) @(posedge clk);
    storeData <= 2'b00;
    repeat (4) @(posedge clk);
    check(q, 2'b11);
    $display("latch test done");
  endtask : t_latch
  task automatic t_ram;
    bus(1, logic_cell_pkg::OFS_CONFIG, 32'h02c0);
    bus(1, logic_cell_pkg::OFS_RAM_INIT, 32'h6);
    bus(1, logic_cell_pkg::OFS_CONTROL, 32'h2);
    firstGenInputs <= 4'h1;
    repeat (5) @(posedge clk);
    check(ramOut, 2'b11);
    writeEnable <= 1'b1;
    cellDataInOne <= 1'b1;
    repeat (4) @(posedge clk);
    writeEnable <= 1'b0;
    cellDataInOne <= 1'b0;
    globalInitSignal <= 1'b1;
    repeat (6) @(posedge clk);
    globalInitSignal <= 1'b0;
    check(ramOut, 2'b10);
    bus(0, logic_cell_pkg::OFS_STATUS, 0);
    check(rv, 32'h0000_0208);
    bus(1, logic_cell_pkg::OFS_CONFIG, 32'h06c0);
    firstGenInputs <= 4'h2;
    cellDataInZero <= 1'b1;
    cellDataInOne <= 1'b1;
    writeEnable <= 1'b1;
    repeat (4) @(posedge clk);
    writeEnable <= 1'b0;
    repeat (2) @(posedge clk);
    cellDataInOne <= 1'b0;
    repeat (5) @(posedge clk);
    check(ramOut, 2'b00);
    cellDataInOne <= 1'b1;
    repeat (5) @(posedge clk);
    check(ramOut, 2'b01);
    $display("ram test done");
  endtask : t_ram
  task automatic t_carry;
    for (int s = 0; s < 2; s++) begin
      bus(1, logic_cell_pkg::OFS_CONFIG, 32'h00c0 | (s << 13));
      for (int k = 0; k < 16; k++) begin
        firstGenInputs <= {2'b00, k[2], k[0]};
        secondGenInputs <= {2'b00, k[3], k[1]};
        carryIn <= k[0] ^ k[3];
        repeat (5) @(posedge clk);
        e = {1'b0, k[1:0]} + {1'b0, k[3:2] ^ {2{s[0]}}} + {2'b00, k[0] ^ k[3]};
        check({carryOut, sum}, e);
      end
    end
    bus(1, logic_cell_pkg::OFS_CONFIG, 32'h18e0);
    repeat (5) @(posedge clk);
    check({carryOutDown, carryOutRight}, 2'b00);
    bus(1, logic_cell_pkg::OFS_CONFIG, 32'h08c0);
    firstGenInputs <= 4'h3;
    secondGenInputs <= 4'h1;
    carryIn <= 1'b0;
    downwardCarryIn <= 1'b1;
    repeat (5) @(posedge clk);
    check({carryOut, carryOutDown, carryOutRight, sum}, 5'b01001);
    bus(1, logic_cell_pkg::OFS_CONFIG, 32'h10c0);
    repeat (5) @(posedge clk);
    check({carryOut, carryOutDown, carryOutRight, sum}, 5'b00100);
    bus(1, logic_cell_pkg::OFS_CONFIG, 32'h40e0);
    firstGenInputs <= 4'h0;
    secondGenInputs <= 4'h8;
    repeat (5) @(posedge clk);
    check({carryOut, sum}, 3'b100);
    bus(1, logic_cell_pkg::OFS_CONFIG, 32'hc0e0);
    repeat (5) @(posedge clk);
    check({carryOut, sum}, 3'b000);
    $display("carry test done");
  endtask : t_carry
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    {clk, cellClockEnableIn, localSetResetIn, globalInitSignal, cellDataInZero, cellDataInOne} = 0;
    {writeEnable, carryIn, downwardCarryIn, read, write, pulseReq, storeData} = 0;
    {firstGenInputs, secondGenInputs, address, writedata} = 0;
    byteenable = 4'hf;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_flop();
    t_edge_init();
    t_latch();
    t_ram();
    t_carry();
    test_done();
  end
endmodule : logic_cell_tb_top
